// ### rtl/gfm_mirror_regs.sv
// function 1 configuration mirror bank of the integrated graphics device
// assumes a single-cycle configuration port and same-clock inputs
`timescale 1ns/100ps
`default_nettype none
`include "gfm_defines.svh"
module gfm_mirror_regs #(
	parameter int unsigned HOLD_CYC = `GFM_RST_HOLD_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	// configuration accesses to this function
	input  wire logic        cfg_req,
	input  wire logic        cfg_wr,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic             cfg_ack,
	output logic      [31:0] cfg_rdata,
	// primary reset register writes from function 0
	input  wire logic        f0_grst_wr,
	input  wire logic [7:0]  f0_grst_wdata,
	output logic      [7:0]  f0_grst_rdata,
	output logic      [15:0] f0_pmcap_rdata,
	// memory map inputs
	input  wire logic        igd_enable,
	input  wire logic [11:0] top_of_low_used_dram,
	input  wire logic [6:0]  stolen_size_mb,
	// graphics reset effects
	output logic             render_rst,
	output logic             display_rst,
	output logic             mmio_defaults_restore,
	output logic             ring_ptr_clear,
	output logic             cmd_fetch_drop,
	output logic             display_halt,
	output logic             legacy_vga_unavail,
	output logic             gfx_io_unavail
);
	initial begin
		if (HOLD_CYC < 8 || HOLD_CYC > 4096) $error("hold count out of range");
	end

	gfm_rst_if rif ();

	logic [11:0] stolen_memory_base;
	logic [7:0]  graphics_reset_register_q, graphics_reset_register_d;
	logic        start_q, start_d;
	logic        ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic [31:0] read_mux;
	logic [15:0] power_mgmt_capability_id;
	logic        trig_set;
	logic [12:0] trig_age_q, trig_age_d;

	// ============================================================
	// stolen memory base
	gfm_stolen_calc #(
		.FIELD_W (`GFM_STOLEN_W)
	) u_stolen (
		.clk                  (clk),
		.rst_n                (rst_n),
		.igd_enable           (igd_enable),
		.top_of_low_used_dram (top_of_low_used_dram),
		.stolen_size_mb       (stolen_size_mb),
		.stolen_memory_base_q (stolen_memory_base)
	);

	// ============================================================
	// reset sequencer
	gfm_reset_seq #(
		.HOLD_CYC (HOLD_CYC)
	) u_seq (
		.clk   (clk),
		.rst_n (rst_n),
		.rif   (rif.seq)
	);

	// ============================================================
	// power management capability id, one copy for both functions
	assign power_mgmt_capability_id = {`GFM_NEXT_CAPABILITY_POINTER, `GFM_CAPABILITY_IDENTIFIER};
	assign f0_pmcap_rdata           = power_mgmt_capability_id;

	// ============================================================
	// graphics reset register, written only through function 0
	// a retrigger while busy is dropped: software must poll first
	assign trig_set = f0_grst_wr && f0_grst_wdata[`GFM_TRIG_BIT]
		&& !graphics_reset_register_q[`GFM_TRIG_BIT] && !rif.busy;

	always_comb begin
		graphics_reset_register_d = graphics_reset_register_q;
		start_d                   = 1'b0;
		if (rif.done) begin
			graphics_reset_register_d[`GFM_TRIG_BIT] = 1'b0;
		end
		if (trig_set) begin
			graphics_reset_register_d[`GFM_DOM_MSB:`GFM_DOM_LSB] =
				f0_grst_wdata[`GFM_DOM_MSB:`GFM_DOM_LSB];
			graphics_reset_register_d[`GFM_TRIG_BIT] = 1'b1;
			start_d = 1'b1;
		end else if (f0_grst_wr && !graphics_reset_register_q[`GFM_TRIG_BIT]
			&& !rif.busy) begin
			graphics_reset_register_d[`GFM_DOM_MSB:`GFM_DOM_LSB] =
				f0_grst_wdata[`GFM_DOM_MSB:`GFM_DOM_LSB];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			graphics_reset_register_q <= `GFM_GRST_RST;
			start_q                   <= 1'b0;
		end else begin
			graphics_reset_register_q <= graphics_reset_register_d;
			start_q                   <= start_d;
		end
	end

	assign rif.start  = start_q;
	assign rif.domain = gfm_pkg::gfm_dom_e'(
		graphics_reset_register_q[`GFM_DOM_MSB:`GFM_DOM_LSB]);
	assign f0_grst_rdata = graphics_reset_register_q;

	// ============================================================
	// reset effects on the graphics core
	assign render_rst            = rif.render_rst;
	assign display_rst           = rif.display_rst;
	assign mmio_defaults_restore = rif.render_rst;
	assign ring_ptr_clear        = rif.render_rst;
	assign cmd_fetch_drop        = rif.render_rst;
	assign display_halt          = rif.display_rst;
	assign legacy_vga_unavail    = rif.render_rst;
	assign gfx_io_unavail        = rif.render_rst;

	// ============================================================
	// trigger age, read only by the clear-time checks
	// saturates so a stuck trigger keeps failing instead of wrapping
	always_comb begin
		trig_age_d = '0;
		if (graphics_reset_register_q[`GFM_TRIG_BIT]) begin
			trig_age_d = trig_age_q;
			if (trig_age_q != '1) begin
				trig_age_d = trig_age_q + 13'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_age_q <= '0;
		end else begin
			trig_age_q <= trig_age_d;
		end
	end

	// ============================================================
	// configuration read path, never gated by graphics reset
	always_comb begin
		read_mux = '0;
		unique case ({cfg_addr[7:2], 2'h0})
			`GFM_OFF_STOLEN: begin
				read_mux[31:`GFM_STOLEN_LSB] = stolen_memory_base;
			end
			`GFM_OFF_SCRATCH: begin
				read_mux[15:0] = `GFM_SCRATCH_RST;
			end
			`GFM_OFF_GRST: begin
				read_mux[7:0] = graphics_reset_register_q;
			end
			`GFM_OFF_PMCAP: begin
				read_mux[15:0] = power_mgmt_capability_id;
			end
			default: begin
				read_mux = '0;
			end
		endcase
	end

	// writes are acknowledged like reads and store nothing
	always_comb begin
		ack_d   = cfg_req;
		rdata_d = '0;
		if (cfg_req && !cfg_wr) begin
			rdata_d = read_mux;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q   <= 1'b0;
			rdata_q <= '0;
		end else begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign cfg_ack   = ack_q;
	assign cfg_rdata = rdata_q;

	// ============================================================
	// checks
	sequence s_cfg_read(logic [7:0] off);
		cfg_req && !cfg_wr && cfg_addr[7:2] == 6'(off >> 2);
	endsequence

	sequence s_trig_write;
		f0_grst_wr && f0_grst_wdata[`GFM_TRIG_BIT]
			&& !graphics_reset_register_q[`GFM_TRIG_BIT] && !rif.busy;
	endsequence

	a_stolen_readback: assert property (@(posedge clk) disable iff (!rst_n)
		s_cfg_read(`GFM_OFF_STOLEN) |=> cfg_ack
		&& cfg_rdata == {$past(stolen_memory_base), 20'h00000})
		else $error("stolen base read mismatch");

	a_scratch_zero: assert property (@(posedge clk) disable iff (!rst_n)
		s_cfg_read(`GFM_OFF_SCRATCH) |=> cfg_rdata == 32'h00000000)
		else $error("scratch register not zero");

	a_grst_mirror: assert property (@(posedge clk) disable iff (!rst_n)
		s_cfg_read(`GFM_OFF_GRST)
		|=> cfg_rdata == {24'h000000, $past(f0_grst_rdata)})
		else $error("reset mirror differs from primary");

	a_pmcap_value: assert property (@(posedge clk) disable iff (!rst_n)
		s_cfg_read(`GFM_OFF_PMCAP)
		|=> cfg_rdata == {16'h0000, f0_pmcap_rdata} && cfg_rdata == 32'h00000001)
		else $error("capability id read wrong");

	a_trig_starts: assert property (@(posedge clk) disable iff (!rst_n)
		s_trig_write |=> graphics_reset_register_q[`GFM_TRIG_BIT] ##1 render_rst
		&& gfx_io_unavail && cmd_fetch_drop)
		else $error("trigger did not start reset");

	a_trig_held: assert property (@(posedge clk) disable iff (!rst_n)
		s_trig_write |=> graphics_reset_register_q[`GFM_TRIG_BIT] [*2])
		else $error("trigger bit dropped early");

	a_trig_clears: assert property (@(posedge clk) disable iff (!rst_n)
		graphics_reset_register_q[`GFM_TRIG_BIT] |-> trig_age_q <= 13'(HOLD_CYC + 1))
		else $error("trigger bit never cleared");

	// clearing early would let software retrigger into a live reset
	a_trig_clear_late: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(graphics_reset_register_q[`GFM_TRIG_BIT])
		|-> trig_age_q == 13'(HOLD_CYC + 2))
		else $error("trigger bit cleared before reset end");

	a_cfg_alive: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_req && render_rst |=> cfg_ack)
		else $error("config access lost during reset");

	a_cfg_write_ro: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_req && cfg_wr && !f0_grst_wr && !rif.busy
		|=> cfg_ack && cfg_rdata == 32'h00000000 && $stable(graphics_reset_register_q))
		else $error("config write altered a mirror");

	a_display_halt: assert property (@(posedge clk) disable iff (!rst_n)
		display_rst |-> display_halt && render_rst)
		else $error("display reset without halt");

	// ============================================================
	// checks on standing levels and the config port shape
	sequence s_effects_on;
		render_rst && mmio_defaults_restore && ring_ptr_clear && cmd_fetch_drop
			&& legacy_vga_unavail && gfx_io_unavail;
	endsequence

	a_effects_track: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(render_rst) |-> s_effects_on [*8])
		else $error("reset effects not held with render reset");

	a_effects_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		!render_rst |-> !mmio_defaults_restore && !ring_ptr_clear && !cmd_fetch_drop
		&& !legacy_vga_unavail && !gfx_io_unavail)
		else $error("reset effect without render reset");

	a_display_full_only: assert property (@(posedge clk) disable iff (!rst_n)
		display_rst |-> rif.domain == gfm_pkg::GFM_DOM_FULL)
		else $error("display reset on a reserved domain");

	a_start_idle: assert property (@(posedge clk) disable iff (!rst_n)
		rif.start |-> !rif.busy)
		else $error("reset started while busy");

	a_grst_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
		graphics_reset_register_q[7:4] == 4'h0 && !graphics_reset_register_q[1])
		else $error("reserved reset bits set");

	a_ack_after_req: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_ack |-> $past(cfg_req))
		else $error("ack without request");

	a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!cfg_ack |-> cfg_rdata == 32'h00000000)
		else $error("read data outside ack");

	a_pmcap_const: assert property (@(posedge clk) disable iff (!rst_n)
		f0_pmcap_rdata == 16'h0001)
		else $error("capability id not constant");
endmodule
`default_nettype wire

// ### common/gfm_defines.svh
// register offsets, field positions, reset values and timing counts
// assumes a 40 MHz core clock and dword-aligned configuration offsets
//
// What this block does
// - reserve 1 to 64 MB below low DRAM top
// - stolen base always stays under 4 GB
// - base register 5Ch reports bits 31:20
// - base equals DRAM top minus stolen size
// - scratch register 60h reads all zero
// - reset register C0h mirrors primary register
// - domain select 00 resets render and display
// - trigger bit 0 starts graphics-only reset
// - hardware clears trigger when reset completes
// - reset restores registers and ring pointers
// - reset drops fetches and halts rendering
// - display domain reset halts display engines
// - VGA memory and IO unavailable during reset
// - configuration registers stay accessible during reset
// - capability id register shared by both functions
// - next capability pointer reads 00h
// - capability identifier reads 01h
`ifndef GFM_DEFINES_SVH
`define GFM_DEFINES_SVH

// ============================================================
// offsets
`define GFM_OFF_STOLEN   8'h5C
`define GFM_OFF_SCRATCH  8'h60
`define GFM_OFF_GRST     8'hC0
`define GFM_OFF_PMCAP    8'hD0

// ============================================================
// fields and reset values
`define GFM_STOLEN_LSB   20
`define GFM_STOLEN_W     12
`define GFM_STOLEN_RST   32'h07800000
`define GFM_BASE_RST     12'h078
`define GFM_SCRATCH_RST  16'h0000
`define GFM_GRST_RST     8'h00
`define GFM_TRIG_BIT     0
`define GFM_DOM_LSB      2
`define GFM_DOM_MSB      3
`define GFM_NEXT_CAPABILITY_POINTER     8'h00
`define GFM_CAPABILITY_IDENTIFIER       8'h01
`define GFM_STOLEN_MIN   7'h01
`define GFM_STOLEN_MAX   7'h40

// ============================================================
// timing
`define GFM_CLK_NS       25
`define GFM_RST_HOLD_NS  1000
`define GFM_RST_HOLD_CYC ((`GFM_RST_HOLD_NS + `GFM_CLK_NS - 1) / `GFM_CLK_NS)

`endif

// ### common/gfm_pkg.sv
// types shared by the mirror bank and its reset sequencer
// assumes nothing beyond a SystemVerilog compiler
package gfm_pkg;
	typedef enum logic [1:0] {
		GFM_DOM_FULL = 2'h0,
		GFM_DOM_RSV1 = 2'h1,
		GFM_DOM_RSV2 = 2'h2,
		GFM_DOM_RSV3 = 2'h3
	} gfm_dom_e;

	typedef enum logic [1:0] {
		GFM_ST_IDLE,
		GFM_ST_HOLD,
		GFM_ST_DONE
	} gfm_seq_e;
endpackage

// ### common/gfm_rst_if.sv
// handshake between the reset register and the reset sequencer
// assumes one clock shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface gfm_rst_if;
	logic             start;
	gfm_pkg::gfm_dom_e domain;
	logic             busy;
	logic             done;
	logic             render_rst;
	logic             display_rst;
	modport ctl (output start, output domain, input busy, input done,
		input render_rst, input display_rst);
	modport seq (input start, input domain, output busy, output done,
		output render_rst, output display_rst);
endinterface
`default_nettype wire

// ### rtl/gfm_stolen_calc.sv
// stolen graphics memory base from low DRAM top and stolen size
// assumes inputs from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "gfm_defines.svh"
module gfm_stolen_calc #(
	parameter int unsigned FIELD_W = `GFM_STOLEN_W
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               igd_enable,
	input  wire logic [FIELD_W-1:0] top_of_low_used_dram,
	input  wire logic [6:0]         stolen_size_mb,
	output logic      [FIELD_W-1:0] stolen_memory_base_q
);
	initial begin
		if (FIELD_W != `GFM_STOLEN_W) $error("field width must be 12");
	end

	logic [FIELD_W-1:0] size_clamped;
	logic [FIELD_W-1:0] stolen_memory_base_d;

	// ============================================================
	// base computation
	always_comb begin
		size_clamped = FIELD_W'(stolen_size_mb);
		if (stolen_size_mb < `GFM_STOLEN_MIN) begin
			size_clamped = FIELD_W'(`GFM_STOLEN_MIN);
		end else if (stolen_size_mb > `GFM_STOLEN_MAX) begin
			size_clamped = FIELD_W'(`GFM_STOLEN_MAX);
		end
		if (!igd_enable) begin
			size_clamped = '0;
		end
		// 12-bit field of 1 MB units cannot reach 4 GB; clamp at 0 on underflow
		if (top_of_low_used_dram >= size_clamped) begin
			stolen_memory_base_d = top_of_low_used_dram - size_clamped;
		end else begin
			stolen_memory_base_d = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stolen_memory_base_q <= `GFM_BASE_RST;
		end else begin
			stolen_memory_base_q <= stolen_memory_base_d;
		end
	end

	a_stolen_below_top: assert property (@(posedge clk) disable iff (!rst_n)
		##1 stolen_memory_base_q <= $past(top_of_low_used_dram))
		else $error("stolen base above low DRAM top");

	a_stolen_size_ok: assert property (@(posedge clk) disable iff (!rst_n)
		igd_enable && top_of_low_used_dram >= FIELD_W'(`GFM_STOLEN_MAX)
		|=> (($past(top_of_low_used_dram) - stolen_memory_base_q) >= FIELD_W'(1))
		&& (($past(top_of_low_used_dram) - stolen_memory_base_q) <= FIELD_W'(64)))
		else $error("stolen size outside 1 to 64 MB");
endmodule
`default_nettype wire

// ### rtl/gfm_reset_seq.sv
// graphics-only reset sequencer: holds domain resets for a fixed time
// assumes start is a one-cycle pulse raised only while idle
`timescale 1ns/100ps
`default_nettype none
`include "gfm_defines.svh"
module gfm_reset_seq #(
	parameter int unsigned HOLD_CYC = `GFM_RST_HOLD_CYC
) (
	input  wire logic clk,
	input  wire logic rst_n,
	gfm_rst_if.seq    rif
);
	initial begin
		if (HOLD_CYC < 8 || HOLD_CYC > 4096) $error("hold count out of range");
	end

	gfm_pkg::gfm_seq_e state_q, state_d;
	logic [12:0]       cnt_q, cnt_d;
	logic              render_q, render_d;
	logic              display_q, display_d;

	// ============================================================
	// sequencer
	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		render_d  = render_q;
		display_d = display_q;
		unique case (state_q)
			gfm_pkg::GFM_ST_IDLE: begin
				if (rif.start) begin
					state_d   = gfm_pkg::GFM_ST_HOLD;
					cnt_d     = 13'(HOLD_CYC - 1);
					render_d  = 1'b1;
					// reserved codes spare the display side
					display_d = (rif.domain == gfm_pkg::GFM_DOM_FULL);
				end
			end
			gfm_pkg::GFM_ST_HOLD: begin
				if (cnt_q == '0) begin
					state_d   = gfm_pkg::GFM_ST_DONE;
					render_d  = 1'b0;
					display_d = 1'b0;
				end else begin
					cnt_d = cnt_q - 13'h1;
				end
			end
			gfm_pkg::GFM_ST_DONE: begin
				state_d = gfm_pkg::GFM_ST_IDLE;
			end
			default: begin
				state_d = gfm_pkg::GFM_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= gfm_pkg::GFM_ST_IDLE;
			cnt_q     <= '0;
			render_q  <= 1'b0;
			display_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			render_q  <= render_d;
			display_q <= display_d;
		end
	end

	assign rif.render_rst  = render_q;
	assign rif.display_rst = display_q;
	assign rif.busy        = (state_q != gfm_pkg::GFM_ST_IDLE);
	assign rif.done        = (state_q == gfm_pkg::GFM_ST_DONE);

	// ============================================================
	// checks
	sequence s_hold_8;
		rif.render_rst [*8];
	endsequence

	a_hold_min_len: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rif.render_rst) |-> s_hold_8)
		else $error("render reset shorter than minimum");

	a_full_both_dom: assert property (@(posedge clk) disable iff (!rst_n)
		rif.start && !rif.busy && rif.domain == gfm_pkg::GFM_DOM_FULL
		|=> rif.render_rst && rif.display_rst)
		else $error("full reset missed a domain");

	a_done_follows: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(rif.render_rst) |-> rif.done ##1 !rif.busy)
		else $error("done not raised at reset end");
endmodule
`default_nettype wire

// ### tb/gfm_host_model.sv
// host side model: function 1 config cycles and function 0 reset writes
// assumes the single-cycle config port of the mirror bank, one clock
`timescale 1ns/100ps
`default_nettype none
module gfm_host_model (
	input  wire logic        clk,
	input  wire logic        cfg_ack,
	input  wire logic [31:0] cfg_rdata,
	output logic             cfg_req,
	output logic             cfg_wr,
	output logic      [7:0]  cfg_addr,
	output logic      [31:0] cfg_wdata,
	output logic             f0_grst_wr,
	output logic      [7:0]  f0_grst_wdata
);
	// ============================================================
	// idle levels
	initial begin
		cfg_req = 1'b0;
		cfg_wr = 1'b0;
		cfg_addr = 8'hFF;
		cfg_wdata = 32'h5A5A5A5A;
		f0_grst_wr = 1'b0;
		f0_grst_wdata = 8'hA5;
	end

	// ============================================================
	// one config access; answer sampled 1 ns after the taking edge
	task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic ack, output logic [31:0] rdata);
		@(posedge clk);
		cfg_req <= 1'b1;
		cfg_wr <= wr;
		cfg_addr <= addr;
		cfg_wdata <= wdata;
		@(posedge clk);
		cfg_req <= 1'b0;
		// released address and data lines never keep the last value; cfg_wr does
		cfg_addr <= ~addr;
		cfg_wdata <= ~wdata;
		#1;
		ack = cfg_ack;
		rdata = cfg_rdata;
	endtask

	// ============================================================
	// reset register write; caller waits for the trigger to clear first
	task automatic f0_write(input logic [7:0] data);
		@(posedge clk);
		f0_grst_wr <= 1'b1;
		f0_grst_wdata <= data;
		@(posedge clk);
		f0_grst_wr <= 1'b0;
		f0_grst_wdata <= ~data;
	endtask
endmodule
`default_nettype wire

// ### tb/graphics_func1_mirror_regs_tb.sv
// self-checking bench for the function 1 mirror bank
// assumes the host model drives every config and function 0 write
`timescale 1ns/100ps
`default_nettype none
module graphics_func1_mirror_regs_tb;
	localparam int unsigned HOLD = 8;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cfg_req, cfg_wr, cfg_ack, f0_grst_wr, igd_enable = 1'b1;
	logic [7:0]  cfg_addr, f0_grst_wdata, f0_grst_rdata;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic [15:0] f0_pmcap_rdata;
	logic [11:0] top_of_low_used_dram = 12'h080;
	logic [6:0]  stolen_size_mb = 7'h08;
	logic        render_rst, display_rst, mmio_defaults_restore, ring_ptr_clear;
	logic        cmd_fetch_drop, display_halt, legacy_vga_unavail, gfx_io_unavail;
	int          mismatches = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          rcnt, dcnt;

	always #12.5 clk = ~clk;

	gfm_mirror_regs #(.HOLD_CYC(HOLD)) dut (.clk(clk), .rst_n(rst_n), .cfg_req(cfg_req),
		.cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(4'hF), .cfg_wdata(cfg_wdata),
		.cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .f0_grst_wr(f0_grst_wr),
		.f0_grst_wdata(f0_grst_wdata), .f0_grst_rdata(f0_grst_rdata),
		.f0_pmcap_rdata(f0_pmcap_rdata), .igd_enable(igd_enable),
		.top_of_low_used_dram(top_of_low_used_dram), .stolen_size_mb(stolen_size_mb),
		.render_rst(render_rst), .display_rst(display_rst),
		.mmio_defaults_restore(mmio_defaults_restore), .ring_ptr_clear(ring_ptr_clear),
		.cmd_fetch_drop(cmd_fetch_drop), .display_halt(display_halt),
		.legacy_vga_unavail(legacy_vga_unavail), .gfx_io_unavail(gfx_io_unavail));

	gfm_host_model host (.clk(clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
		.cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.f0_grst_wr(f0_grst_wr), .f0_grst_wdata(f0_grst_wdata));

	// ============================================================
	// counters: domain reset length and run ceiling
	always @(posedge clk) begin
		if (render_rst === 1'b1)
			rcnt++;
		if (display_rst === 1'b1)
			dcnt++;
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			results();
		end
	end

	// ============================================================
	// helpers
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
		logic        ack;
		logic [31:0] rd;
		host.access(1'b0, addr, 32'h00000000, ack, rd);
		check({31'h0, ack}, 32'h00000001, "read ack");
		check(rd, exp, "read data");
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ============================================================
	// scenarios
	task automatic t_defaults();
		rd_chk(8'h5C, 32'h07800000);
		rd_chk(8'h60, 32'h00000000);
		rd_chk(8'hC0, 32'h00000000);
		rd_chk(8'hD0, 32'h00000001);
		rd_chk(8'h40, 32'h00000000);
		check({16'h0, f0_pmcap_rdata}, 32'h00000001, "shared capability_identifier");
		$display("test defaults done");
	endtask

	task automatic t_stolen();
		// en, size, expected base with top 800h; sizes 0 and 7Fh hit the clamps
		logic [19:0] tbl [5] = '{{1'b1, 7'h40, 12'h7C0}, {1'b1, 7'h01, 12'h7FF},
			{1'b1, 7'h00, 12'h7FF}, {1'b1, 7'h7F, 12'h7C0}, {1'b0, 7'h10, 12'h800}};
		foreach (tbl[i]) begin
			@(posedge clk);
			igd_enable <= tbl[i][19];
			stolen_size_mb <= tbl[i][18:12];
			top_of_low_used_dram <= 12'h800;
			rd_chk(8'h5C, {tbl[i][11:0], 20'h00000});
		end
		$display("test stolen done");
	endtask

	task automatic t_writes();
		logic [7:0]  offs [4] = '{8'h5C, 8'h60, 8'hC0, 8'hD0};
		logic [31:0] exps [4] = '{32'h80000000, 32'h0, 32'h0, 32'h00000001};
		logic        ack;
		logic [31:0] rd;
		foreach (offs[i]) begin
			host.access(1'b1, offs[i], 32'hFFFFFFFF, ack, rd);
			check({31'h0, ack}, 32'h00000001, "write ack");
			rd_chk(offs[i], exps[i]);
		end
		$display("test writes done");
	endtask

	task automatic t_grst(input logic [7:0] wd, input logic disp);
		int n;
		rcnt = 0;
		dcnt = 0;
		host.f0_write(wd);
		n = 0;
		while (f0_grst_rdata[0] !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		check({24'h0, f0_grst_rdata}, {24'h0, wd}, "trigger set");
		rd_chk(8'hC0, {24'h0, wd});
		check({render_rst, display_rst}, {1'b1, disp}, "domains");
		check({mmio_defaults_restore, ring_ptr_clear, cmd_fetch_drop}, 3'h7, "core");
		check({legacy_vga_unavail, gfx_io_unavail, display_halt}, {2'h3, disp}, "io");
		n = 0;
		while (f0_grst_rdata[0] !== 1'b0 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(rcnt, HOLD, "render length");
		check(dcnt, disp ? HOLD : 0, "display length");
		rd_chk(8'hC0, {24'h0, wd & 8'h0C});
		$display("test graphics reset %h done", wd);
	endtask

	// reserved bits written, then a platform reset cuts a running graphics reset
	task automatic t_midreset();
		host.f0_write(8'hF2);
		@(posedge clk);
		#1;
		check({24'h0, f0_grst_rdata}, 32'h00000000, "reserved bits");
		host.f0_write(8'h01);
		repeat (3) @(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		#1;
		check({render_rst, display_rst, f0_grst_rdata}, 32'h00000000, "mid reset");
		@(posedge clk);
		rst_n <= 1'b1;
		rd_chk(8'hC0, 32'h00000000);
		rd_chk(8'h5C, 32'h80000000);
		$display("test mid-run reset done");
	endtask

	// ============================================================
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_defaults();
		t_stolen();
		t_writes();
		t_grst(8'h01, 1'b1);
		t_grst(8'h01, 1'b1);
		t_midreset();
		t_grst(8'h01, 1'b1);
		results();
	end
endmodule
`default_nettype wire
